// ---- src/sto_restart_ctrl.sv ----
// Safe torque off and restart controller with APB registers.
// Assumes the safe stop input, trip output and reset pins are asynchronous.
`timescale 1ns/1ns
module sto_restart_ctrl (
   input  wire logic        pclk,                    // 125 MHz clock
   input  wire logic        presetn,                 // Async reset, low
   input  wire logic        psel,                    // APB select
   input  wire logic        penable,                 // APB enable
   input  wire logic        pwrite,                  // APB direction
   input  wire logic [7:0]  paddr,                   // APB address
   input  wire logic [31:0] pwdata,                  // APB write data
   output logic             pready,                  // APB ready
   output logic [31:0]      prdata,                  // APB read data
   output logic             pslverr,                 // APB error
   input  wire logic        safe_stop_input,         // Safety input pin
   input  wire logic        thermistor_trip_output,  // Card trip pin, low = trip
   input  wire logic        reset_digital_input_n,   // Reset digital input, low
   input  wire logic        reset_key_n,             // Panel reset key, low
   output logic             drive_enable,            // Output stage enable
   output logic             brake_engage,            // Mechanical brake
   output logic             sto_active,              // Torque-off indication
   output logic             torque_off_alarm_code,   // Alarm code active
   output logic             torque_off_warning_code, // Warning code active
   output logic             dangerous_failure_alarm, // Dangerous failure
   output logic             irq                      // Interrupt, level
);

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic [1:0] sync_stop;   // Safety input stages
   logic [1:0] sync_trip;   // Card trip stages
   logic [1:0] sync_din;    // Digital reset stages
   logic [1:0] sync_key;    // Key reset stages
   logic       stop_ok;     // Supply present
   logic       trip_ok;     // Card not tripped
   logic       din_rst;     // Digital reset level
   logic       key_rst;     // Key reset level

   // Two flops for each pin before any use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_stop <= 2'h0;
         sync_trip <= 2'h0;
         sync_din  <= 2'h3;
         sync_key  <= 2'h3;
      end else begin
         sync_stop <= {sync_stop[0], safe_stop_input};
         sync_trip <= {sync_trip[0], thermistor_trip_output};
         sync_din  <= {sync_din[0], reset_digital_input_n};
         sync_key  <= {sync_key[0], reset_key_n};
      end
   end

   assign stop_ok = sync_stop[1];
   assign trip_ok = sync_trip[1];
   assign din_rst = ~sync_din[1];
   assign key_rst = ~sync_key[1];

   // ************************************************************
   // Reset edge detection
   // ************************************************************
   logic din_q;      // Previous digital reset
   logic key_q;      // Previous key reset
   logic bus_rst;    // Bus reset pulse
   logic reset_req;  // Any reset edge

   // Edge registers for the pin resets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_q <= 1'b0;
         key_q <= 1'b0;
      end else begin
         din_q <= din_rst;
         key_q <= key_rst;
      end
   end

   assign reset_req = bus_rst | (din_rst & ~din_q) | (key_rst & ~key_q);

   // ************************************************************
   // Mode decoding
   // ************************************************************
   logic [3:0] mode;        // Selector register
   logic       card_fitted; // Thermistor card present

   // Automatic restart for this selector and card setting
   function automatic logic is_auto(input logic [3:0] m, input logic card);
      if (card)
         is_auto = (m == sto_pkg::MODE_MIX_WARN) || (m == sto_pkg::MODE_MIX_AW)
                   || (m == sto_pkg::MODE_STO_WARN);
      else
         is_auto = (m == sto_pkg::MODE_STO_WARN);
   endfunction

   // Selector value legal for the card setting
   function automatic logic mode_legal(input logic [3:0] m, input logic card);
      if (m == sto_pkg::MODE_STO_ALARM || m == sto_pkg::MODE_STO_WARN)
         mode_legal = 1'b1;
      else if (m >= sto_pkg::MODE_THERM_ALARM && m <= sto_pkg::MODE_MIX_WA)
         mode_legal = card;
      else
         mode_legal = 1'b0;
   endfunction

   logic auto_mode;   // Automatic restart selected
   logic sto_only;    // Modes without card handling
   logic therm_only;  // Card-only modes
   logic stop_low;    // Input removed
   logic danger;      // Misconfiguration trip

   assign auto_mode  = is_auto(mode, card_fitted);
   assign sto_only   = (mode == sto_pkg::MODE_STO_ALARM) || (mode == sto_pkg::MODE_STO_WARN);
   assign therm_only = (mode == sto_pkg::MODE_THERM_ALARM) || (mode == sto_pkg::MODE_THERM_WARN);
   assign stop_low   = ~stop_ok;
   // Card trip in plain modes, relay trip in card-only modes
   assign danger = stop_low & card_fitted &
                   ((sto_only & ~trip_ok) | (therm_only & trip_ok));

   // ************************************************************
   // Torque-off state machine
   // ************************************************************
   sto_pkg::sto_state_t state;       // Current state
   sto_pkg::sto_state_t next_state;  // Next state

   // Next state selection
   always_comb begin
      next_state = state;
      case (state)
         sto_pkg::ST_RUN: begin
            if (danger)
               next_state = sto_pkg::ST_LOCKED;
            else if (stop_low)
               next_state = sto_pkg::ST_OFF;
         end
         sto_pkg::ST_OFF: begin
            if (danger)
               next_state = sto_pkg::ST_LOCKED;
            else if (stop_ok && auto_mode)
               next_state = sto_pkg::ST_RUN;
            else if (stop_ok)
               next_state = sto_pkg::ST_WAIT_RST;
         end
         sto_pkg::ST_WAIT_RST: begin
            // Misconfiguration trip while waiting locks at once
            if (danger)
               next_state = sto_pkg::ST_LOCKED;
            else if (stop_low)
               next_state = sto_pkg::ST_OFF;
            else if (reset_req)
               next_state = sto_pkg::ST_RUN;
         end
         default: begin
            // Locked: reset only once supply is back
            if (stop_ok && reset_req)
               next_state = sto_pkg::ST_RUN;
         end
      endcase
   end

   // State register, torque off after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         state <= sto_pkg::ST_OFF;
      else
         state <= next_state;
   end

   // ************************************************************
   // Drive outputs, registered
   // ************************************************************
   logic alarm_mode;  // Alarm rather than warning
   assign alarm_mode = ~auto_mode;

   // Output stage and indications
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_enable            <= 1'b0;
         brake_engage            <= 1'b1;
         sto_active              <= 1'b1;
         torque_off_alarm_code   <= 1'b0;
         torque_off_warning_code <= 1'b0;
         dangerous_failure_alarm <= 1'b0;
      end else begin
         // Enable only in run and only with supply present
         drive_enable <= (next_state == sto_pkg::ST_RUN) & stop_ok;
         brake_engage <= (next_state != sto_pkg::ST_RUN);
         sto_active   <= (next_state != sto_pkg::ST_RUN);
         if (state == sto_pkg::ST_RUN && next_state == sto_pkg::ST_OFF) begin
            torque_off_alarm_code   <= alarm_mode;
            torque_off_warning_code <= ~alarm_mode;
         end else if (next_state == sto_pkg::ST_RUN) begin
            torque_off_alarm_code   <= 1'b0;
            torque_off_warning_code <= 1'b0;
         end
         dangerous_failure_alarm <= (next_state == sto_pkg::ST_LOCKED);
      end
   end

   // ************************************************************
   // Event detection and interrupt
   // ************************************************************
   logic [sto_pkg::EV_W-1:0] events;     // Sticky status
   logic [sto_pkg::EV_W-1:0] ev_enable;  // Interrupt enables
   logic [sto_pkg::EV_W-1:0] ev_set;     // Set pulses
   logic [sto_pkg::EV_W-1:0] ev_clr;     // Clear pulses
   logic                     goes_off;   // Entering torque off

   assign goes_off = (state == sto_pkg::ST_RUN) && (next_state != sto_pkg::ST_RUN);
   assign ev_set[sto_pkg::EV_ALARM]     = goes_off & alarm_mode;
   assign ev_set[sto_pkg::EV_WARNING]   = goes_off & ~alarm_mode;
   assign ev_set[sto_pkg::EV_DANGEROUS] = (next_state == sto_pkg::ST_LOCKED) &&
                                          (state != sto_pkg::ST_LOCKED);
   assign ev_set[sto_pkg::EV_RESUME]    = (state != sto_pkg::ST_RUN) &&
                                          (next_state == sto_pkg::ST_RUN);

   // Sticky bits, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         events <= '0;
      else
         events <= (events & ~ev_clr) | ev_set;
   end

   assign irq = |(events & ev_enable);

   // ************************************************************
   // APB slave
   // ************************************************************
   logic wr_en;  // Write access phase
   logic rd_en;  // Read access phase

   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;
   assign bus_rst = wr_en && (paddr == sto_pkg::ADDR_RESET) && pwdata[0];
   assign ev_clr  = (wr_en && paddr == sto_pkg::ADDR_CLEAR) ?
                    pwdata[sto_pkg::EV_W-1:0] : '0;

   // Writable configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode        <= sto_pkg::MODE_RESET;
         ev_enable   <= '0;
         card_fitted <= 1'b0;
      end else if (wr_en) begin
         if (paddr == sto_pkg::ADDR_MODE) begin
            if (mode_legal(pwdata[3:0], card_fitted))
               mode <= pwdata[3:0];
         end else if (paddr == sto_pkg::ADDR_ENABLE) begin
            ev_enable <= pwdata[sto_pkg::EV_W-1:0];
         end else if (paddr == sto_pkg::ADDR_OPTION) begin
            card_fitted <= pwdata[0];
         end
      end
   end

   sto_pkg::sto_status_t status;  // Live status word
   assign status = '{sto_active: sto_active, brake_engage: brake_engage,
                     drive_enable: drive_enable, input_level: stop_ok};

   // Read data, registered in the setup phase; the error below is combinational
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == sto_pkg::ADDR_MODE)
            prdata <= {28'h0, mode};
         else if (paddr == sto_pkg::ADDR_STATUS)
            prdata <= {26'h0, state, status};
         else if (paddr == sto_pkg::ADDR_EVENTS)
            prdata <= {28'h0, events};
         else if (paddr == sto_pkg::ADDR_ENABLE)
            prdata <= {28'h0, ev_enable};
         else if (paddr == sto_pkg::ADDR_OPTION)
            prdata <= {31'h0, card_fitted};
         else
            prdata <= 32'h0000_0000;
      end
   end

   // Unmapped accesses or write-only reads answer with an error
   always_comb begin
      pslverr = 1'b0;
      if (psel && penable) begin
         if (paddr > sto_pkg::ADDR_OPTION || paddr[1:0] != 2'h0)
            pslverr = 1'b1;
         else if (!pwrite && (paddr == sto_pkg::ADDR_RESET || paddr == sto_pkg::ADDR_CLEAR))
            pslverr = 1'b1;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   sequence s_supply_lost;
      !stop_ok;
   endsequence

   AST_OFF_WHEN_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      s_supply_lost |=> !drive_enable) else $error("drive enabled with input low");
   AST_RESPONSE: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(sync_stop[1]) |-> ##[0:2] !drive_enable) else $error("slow torque off");
   AST_INDICATION: assert property (@(posedge pclk) disable iff (!presetn)
      !drive_enable && state != sto_pkg::ST_RUN |-> sto_active) else $error("indication lost");
   AST_NO_FIELD: assert property (@(posedge pclk) disable iff (!presetn)
      drive_enable |-> $past(stop_ok)) else $error("field without supply");
   AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
      state == sto_pkg::ST_WAIT_RST && stop_ok && reset_req |=> state == sto_pkg::ST_RUN)
      else $error("reset ignored");
   AST_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
      state == sto_pkg::ST_OFF && stop_ok && auto_mode && !danger |=> state == sto_pkg::ST_RUN)
      else $error("no automatic restart");
   AST_DANGER: assert property (@(posedge pclk) disable iff (!presetn)
      danger |=> dangerous_failure_alarm ##1 !drive_enable) else $error("dangerous failure missed");
   AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      state == sto_pkg::ST_WAIT_RST && !reset_req |=> !drive_enable && brake_engage)
      else $error("restart without reset");
   AST_RST_NO_SUPPLY: assert property (@(posedge pclk) disable iff (!presetn)
      state == sto_pkg::ST_OFF && !stop_ok |=> state != sto_pkg::ST_RUN)
      else $error("reset without supply");
   AST_WARN: assert property (@(posedge pclk) disable iff (!presetn)
      goes_off && auto_mode && !danger |=> torque_off_warning_code && !torque_off_alarm_code)
      else $error("warning code missing");

   // Locked outcome: alarm shown, stage off, brake on
   sequence s_locked_out;
      dangerous_failure_alarm && !drive_enable && brake_engage;
   endsequence

   // Danger in any state locks at the next edge
   AST_LOCK_ANY: assert property (@(posedge pclk) disable iff (!presetn)
      danger |=> s_locked_out) else $error("lock missed");
   // Locked drive stays down without a reset
   AST_LOCK_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      state == sto_pkg::ST_LOCKED && !reset_req |=> state == sto_pkg::ST_LOCKED)
      else $error("locked drive restarted");
   // With the card, selectors six and nine never restart alone
   AST_CARD_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
      card_fitted && (mode == sto_pkg::MODE_MIX_ALARM || mode == sto_pkg::MODE_MIX_WA) |-> !auto_mode)
      else $error("prevention mode restarts alone");

endmodule

// ---- include/sto_pkg.sv ----
// Package for the safe torque off restart controller.
// Assumes a single pclk domain at 125 MHz and APB register access.
package sto_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] ADDR_MODE    = 8'h00; // Mode selector
   localparam logic [7:0] ADDR_STATUS  = 8'h04; // Live state
   localparam logic [7:0] ADDR_RESET   = 8'h08; // Software reset command
   localparam logic [7:0] ADDR_EVENTS  = 8'h0C; // Sticky event bits
   localparam logic [7:0] ADDR_CLEAR   = 8'h10; // Event clear, write-one
   localparam logic [7:0] ADDR_ENABLE  = 8'h14; // Interrupt enable
   localparam logic [7:0] ADDR_OPTION  = 8'h18; // Thermistor card present

   // ************************************************************
   // Mode selector values and reset value
   // ************************************************************
   localparam logic [3:0] MODE_STO_ALARM    = 4'h1; // Restart prevention
   localparam logic [3:0] MODE_STO_WARN     = 4'h3; // Automatic restart
   localparam logic [3:0] MODE_THERM_ALARM  = 4'h4; // Thermistor only, alarm
   localparam logic [3:0] MODE_THERM_WARN   = 4'h5; // Thermistor only, alarm, same as selector four
   localparam logic [3:0] MODE_MIX_ALARM    = 4'h6; // Mixed, restart prevention
   localparam logic [3:0] MODE_MIX_WARN     = 4'h7; // Mixed, automatic restart
   localparam logic [3:0] MODE_MIX_AW       = 4'h8; // Mixed, automatic restart
   localparam logic [3:0] MODE_MIX_WA       = 4'h9; // Mixed, restart prevention
   localparam logic [3:0] MODE_RESET        = MODE_STO_ALARM;

   // ************************************************************
   // Event bit positions
   // ************************************************************
   localparam int EV_ALARM     = 0; // Torque-off alarm code
   localparam int EV_WARNING   = 1; // Torque-off warning code
   localparam int EV_DANGEROUS = 2; // Dangerous failure alarm
   localparam int EV_RESUME    = 3; // Normal operation resumed
   localparam int EV_W         = 4; // Number of events

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_MHZ       = 125;          // pclk rate
   localparam int RESPONSE_US   = 10000;        // Response limit, 10 ms
   localparam int RESPONSE_CYC  = RESPONSE_US * CLK_MHZ; // Longest, cycles

   // State of the torque-off controller
   typedef enum logic [1:0] {
      ST_RUN,       // Rotating field allowed
      ST_OFF,       // Torque off, input low
      ST_WAIT_RST,  // Input back, waiting for reset
      ST_LOCKED     // Dangerous failure, reset needed
   } sto_state_t;

   // Status bundle shown to software
   typedef struct packed {
      logic       sto_active;   // Torque-off indication
      logic       brake_engage; // Mechanical brake engaged
      logic       drive_enable; // Output stage enabled
      logic       input_level;  // Synchronised input
   } sto_status_t;
endpackage

// ---- testbench/safety_relay_model.sv ----
// Model of the external safety relay that feeds the safe stop input.
// Assumes the bench drives the sensor chain and the card trip level.
`timescale 1ns/1ns
module safety_relay_model (
   input  wire logic pclk,        // Bench clock
   input  wire logic sensor_ok,   // Emergency stop chain closed
   input  wire logic trip_ok,     // Card trip output, high = healthy
   input  wire logic slow,        // Slow contacts on closing
   output logic      stop_supply  // Drives the safe stop input
);
   // ************************************************************
   // Safe AND of both chains
   // ************************************************************
   logic [2:0] lag;   // Closing delay line
   logic       anded; // Both chains healthy
   assign anded = sensor_ok & trip_ok;
   // Contact delay line, only slows the closing edge
   always_ff @(posedge pclk) begin
      lag <= {lag[1:0], anded};
   end
   // Opening is always prompt, closing may lag
   assign stop_supply = slow ? (lag[2] & anded) : anded;
endmodule

// ---- testbench/safe_torque_off_restart_control_tb.sv ----
// Self-checking bench for the safe torque off restart controller.
// Assumes the controller package, the relay model and one 125 MHz clock.
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
   $display("FAIL t=%0t got %0h exp %0h", $time, got, exp); end end
module safe_torque_off_restart_control_tb;
   // ************************************************************
   // Signals
   // ************************************************************
   logic        pclk, presetn, psel, penable, pwrite;   // Bus control
   logic [7:0]  paddr;                                  // Bus address
   logic [31:0] pwdata, prdata;                         // Bus data
   logic        pready, pslverr;                        // Bus answer
   logic        stop_in, sensor_ok, trip_ok, slow;      // Safety chain
   logic        rst_dig_n, rst_key_n;                   // Reset pins
   logic        drive_enable, brake_engage, sto_active; // Drive state
   logic        torque_off_alarm_code, torque_off_warning_code;
   logic        dangerous_failure_alarm, irq;           // Alarms
   int          num_errors, checks_done, cycles;        // Bookkeeping
   // ************************************************************
   // Instances
   // ************************************************************
   sto_restart_ctrl sto_restart_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .safe_stop_input(stop_in), .thermistor_trip_output(trip_ok), .reset_digital_input_n(rst_dig_n),
      .reset_key_n(rst_key_n), .drive_enable(drive_enable), .brake_engage(brake_engage),
      .sto_active(sto_active), .torque_off_alarm_code(torque_off_alarm_code),
      .torque_off_warning_code(torque_off_warning_code), .dangerous_failure_alarm(dangerous_failure_alarm),
      .irq(irq));
   safety_relay_model safety_relay_model_inst (.pclk(pclk), .sensor_ok(sensor_ok), .trip_ok(trip_ok),
      .slow(slow), .stop_supply(stop_in));
   // ************************************************************
   // Helpers
   // ************************************************************
   // Clock, 8 ns period
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   // Verdict
   task automatic tally_and_finish();
      if (num_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Wait whole cycles
   task automatic step(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One bus transfer, waits for ready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   // Register read
   task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
      apb(1'b0, a, 32'h0, q, e);
   endtask
   // Reset pulse on key or digital input
   task automatic pulse(input logic key);
      if (key) begin
         rst_key_n <= 1'b0;
      end else begin
         rst_dig_n <= 1'b0;
      end
      step(4);
      rst_key_n <= 1'b1;
      rst_dig_n <= 1'b1;
      step(6);
   endtask
   // Close both chains and let the input settle
   task automatic restore();
      sensor_ok <= 1'b1;
      trip_ok <= 1'b1;
      step(8);
   endtask
   // Bus reset command, then expect running
   task automatic run_up();
      wr(sto_pkg::ADDR_RESET, 32'h1);
      step(6);
      `CHK(drive_enable, 1'b1);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   // Reset state and selector default
   task automatic t_reset();
      logic [31:0] q;
      logic        e;
      `CHK(drive_enable, 1'b0);
      `CHK(sto_active, 1'b1);
      rd(sto_pkg::ADDR_MODE, q, e);
      `CHK(q, 32'h1);
      rd(8'h1C, q, e);
      `CHK(e, 1'b1);
      rd(sto_pkg::ADDR_STATUS, q, e);
      `CHK(q, {26'h0, sto_pkg::ST_WAIT_RST, 4'hD});
   endtask
   // Restart prevention walk with events and interrupt
   task automatic t_prevent();
      logic [31:0] q;
      logic        e;
      run_up();
      wr(sto_pkg::ADDR_CLEAR, 32'hF);
      wr(sto_pkg::ADDR_ENABLE, 32'h1);
      sensor_ok <= 1'b0;
      step(5);
      `CHK(drive_enable, 1'b0);
      `CHK(brake_engage, 1'b1);
      `CHK(torque_off_alarm_code, 1'b1);
      `CHK(irq, 1'b1);
      pulse(1'b1);
      `CHK(drive_enable, 1'b0);
      `CHK(brake_engage, 1'b1);
      slow <= 1'b1;
      restore();
      `CHK(drive_enable, 1'b0);
      `CHK(sto_active, 1'b1);
      pulse(1'b0);
      `CHK(drive_enable, 1'b1);
      `CHK(sto_active, 1'b0);
      rd(sto_pkg::ADDR_EVENTS, q, e);
      `CHK(q, 32'h9);
      wr(sto_pkg::ADDR_CLEAR, 32'h1);
      `CHK(irq, 1'b0);
      wr(sto_pkg::ADDR_ENABLE, 32'h8);
      `CHK(irq, 1'b1);
      wr(sto_pkg::ADDR_ENABLE, 32'h0);
      `CHK(irq, 1'b0);
      slow <= 1'b0;
   endtask
   // Automatic restart on selector three
   task automatic t_auto();
      logic [31:0] q;
      logic        e;
      wr(sto_pkg::ADDR_MODE, 32'h3);
      rd(sto_pkg::ADDR_MODE, q, e);
      `CHK(q[3:0], sto_pkg::MODE_STO_WARN);
      sensor_ok <= 1'b0;
      step(5);
      `CHK(drive_enable, 1'b0);
      `CHK(torque_off_warning_code, 1'b1);
      `CHK(torque_off_alarm_code, 1'b0);
      restore();
      `CHK(drive_enable, 1'b1);
   endtask
   // Mixed selectors six to nine with the card fitted
   task automatic t_mixed();
      logic [31:0] q;
      logic        e;
      logic        auto;
      wr(sto_pkg::ADDR_MODE, 32'h7);
      rd(sto_pkg::ADDR_MODE, q, e);
      `CHK(q[3:0], sto_pkg::MODE_STO_WARN);
      wr(sto_pkg::ADDR_OPTION, 32'h1);
      for (int i = 6; i <= 9; i++) begin
         auto = (i == 7 || i == 8);
         wr(sto_pkg::ADDR_MODE, 32'(i));
         rd(sto_pkg::ADDR_MODE, q, e);
         `CHK(q, 32'(i));
         sensor_ok <= 1'b0;
         step(5);
         `CHK(drive_enable, 1'b0);
         `CHK(torque_off_alarm_code, !auto);
         restore();
         `CHK(drive_enable, auto);
         if (!auto) begin
            run_up();
         end
      end
   endtask
   // Wrong selector for the tripping chain locks the drive
   task automatic t_danger();
      logic [31:0] q;
      logic        e;
      for (int i = 0; i < 4; i++) begin
         wr(sto_pkg::ADDR_MODE, (i < 2) ? 32'(1 + 2 * i) : 32'(i + 2));
         wr(sto_pkg::ADDR_CLEAR, 32'hF);
         if (i < 2) begin
            trip_ok <= 1'b0;
         end else begin
            sensor_ok <= 1'b0;
         end
         step(5);
         `CHK(dangerous_failure_alarm, 1'b1);
         `CHK(drive_enable, 1'b0);
         rd(sto_pkg::ADDR_EVENTS, q, e);
         `CHK(q[sto_pkg::EV_DANGEROUS], 1'b1);
         restore();
         `CHK(drive_enable, 1'b0);
         run_up();
      end
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {presetn, psel, penable, pwrite, slow} = 5'h00;
      {paddr, pwdata} = 40'h0;
      {sensor_ok, trip_ok, rst_dig_n, rst_key_n} = 4'hF;
      {num_errors, checks_done, cycles} = 0;
      step(12);
      presetn <= 1'b1;
      step(4);
      t_reset();
      t_prevent();
      t_auto();
      t_mixed();
      t_danger();
      tally_and_finish();
   end
endmodule
